// *** bench/fcsm_flash_model.sv ***
// behavioural byte-wide flash answering the host's pins
`timescale 1ns/1ns

module fcsm_flash_model
    import fcsm_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE  = 8'h3c, // arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'hc3, // arbitrary value
    parameter logic [7:0] CONT_CODE   = 8'h5e, // arbitrary value
    parameter logic [7:0] PROT_MAP    = 8'h00
)
(
    input  wire fcsm_pins_t   pins,
    input  wire logic [31:0]  busy_len,
    output logic [DATA_W-1:0] dq_in
);
    logic [7:0]        mem [16];
    logic [ADDR_W-1:0] wa;
    logic [7:0]        wd;
    logic [7:0]        setup;
    logic [7:0]        junk = 8'h5a;
    int                step = 0;
    int                busy = 0;
    bit                ident, operation_fail_flag, tog, pgm, inhibit;
    time               t_fall;
    wire               sel_wr = !pins.ce_n && !pins.we_n && pins.oe_n;
    wire               sel_rd = !pins.ce_n && !pins.oe_n && pins.we_n;
    ////////////////////////////////////////////////////////////////
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        #1 inhibit = pins.we_n === 1'b0 && pins.ce_n === 1'b0 && pins.oe_n === 1'b1;
    end
    // a released bus moves every cycle so a stale value cannot pass
    initial forever #100 junk = junk + 8'h3b;

    function automatic logic [7:0] id_byte(input logic [ADDR_W-1:0] a);
        case (a[7:0])
            8'h00: return MAKER_CODE;
            8'h01: return DEVICE_CODE;
            8'h11: return CONT_CODE;
            8'h02: return {7'h00, PROT_MAP[a[18:16]]};
            default: return 8'h00;
        endcase
    endfunction : id_byte

    task automatic take(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        bit ok;
        if (busy > 0) begin
            if (operation_fail_flag && d == CMD_RESET) begin
                busy = 0;
                operation_fail_flag = 0;
            end
            return;
        end
        if (pgm) begin
            pgm = 0;
            wd = d;
            operation_fail_flag = |(d & ~mem[a[3:0]]);
            mem[a[3:0]] &= d;
            busy = busy_len;
            return;
        end
        if (d == CMD_RESET) begin
            step = 0;
            ident = 0;
            return;
        end
        ok = (step == 0 || step == 3) ? (a == UNLOCK1_ADDR && d == UNLOCK1_DATA)
           : (step == 1 || step == 4) ? (a == UNLOCK2_ADDR && d == UNLOCK2_DATA)
           : (step == 2) ? (a == UNLOCK1_ADDR && d inside {CMD_PROGRAM, CMD_ERASE_SETUP, CMD_AUTOSELECT})
           : (a == UNLOCK1_ADDR && d == CMD_CHIP_ERASE);
        if (!ok) step = 0;
        else begin
            if (step == 2) setup = d;
            step++;
            if (step == 3 && setup == CMD_PROGRAM) pgm = 1;
            if (step == 3 && setup == CMD_AUTOSELECT) ident = 1;
            if (step == 3 && setup != CMD_ERASE_SETUP) step = 0;
            if (step == 6) begin
                step = 0;
                foreach (mem[i]) mem[i] = 8'hff;
                busy = 2 * busy_len;
                wd = 8'hff;
            end
        end
    endtask : take

    always @(posedge sel_wr) begin
        wa = pins.addr;
        t_fall = $time;
    end
    always @(negedge sel_wr) begin
        if ($time - t_fall < 5 || inhibit) inhibit = 0;
        else take(wa, pins.dq_out);
    end
    always @(posedge sel_rd) begin
        if (busy > 0) begin
            tog = !tog;
            if (!operation_fail_flag) busy--;
        end
    end
    always @* begin
        if (!pins.dq_oe_n) dq_in = pins.dq_out;
        else if (sel_rd) dq_in = (busy > 0) ? {~wd[7], tog, operation_fail_flag, 5'h00}
                                 : ident ? id_byte(pins.addr) : mem[pins.addr[3:0]];
        else dq_in = junk;
    end
endmodule : fcsm_flash_model

// *** bench/fcsm_host_checker.sv ***
// port assertions for the host sequencer, bound into every instance
`timescale 1ns/1ns

module fcsm_host_checker
    import fcsm_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              rst,
    input wire logic              clk_en,
    input wire fcsm_cmd_t         cmd,
    input wire logic              cmd_valid,
    input wire logic              cmd_ready,
    input wire logic              rsp_valid,
    input wire logic [DATA_W-1:0] rsp_data,
    input wire logic              rsp_fail,
    input wire fcsm_pins_t        pins,
    input wire logic [DATA_W-1:0] dq_in
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire               take = clk_en && cmd_valid && cmd_ready;
    logic [ADDR_W-1:0] held_addr;
    ////////////////////////////////////////////////////////////////
    // one command in flight, so the taken address stays valid until the answer
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) held_addr <= '0;
        else if (take) held_addr <= cmd.addr;
    end
    a_write_qualify: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n && !pins.dq_oe_n)
        else $error("strobe low without select or with gate low");
    a_read_no_drive: assert property (!pins.oe_n |-> pins.we_n && pins.dq_oe_n)
        else $error("host drives the bus during a read");
    a_strobe_width: assert property ($fell(pins.we_n) |=> $rose(pins.we_n))
        else $error("write strobe not one whole cycle");
    a_addr_setup: assert property ($fell(pins.we_n) |-> $stable(pins.addr) && $stable(pins.dq_out))
        else $error("address or data moved at strobe fall");
    a_data_hold: assert property ($rose(pins.we_n) |-> !pins.ce_n && !pins.dq_oe_n && $stable(pins.dq_out))
        else $error("data released at strobe rise");
    a_reset_word: assert property (take && cmd.op == FCSM_OP_RESET |-> ##[1:12] (!pins.we_n && pins.addr == held_addr && pins.dq_out == CMD_RESET))
        else $error("reset write missing");
    a_first_unlock: assert property (take && cmd.op == FCSM_OP_PROGRAM |-> ##[1:12] (!pins.we_n && pins.addr == UNLOCK1_ADDR && pins.dq_out == UNLOCK1_DATA))
        else $error("first unlock write missing");
    a_erase_sixth: assert property (take && cmd.op == FCSM_OP_CHIP_ERASE |-> ##[20:60] (!pins.we_n && pins.addr == UNLOCK1_ADDR && pins.dq_out == CMD_CHIP_ERASE))
        else $error("chip erase command write missing");
    a_autosel_exit: assert property (take && cmd.op == FCSM_OP_AUTOSEL |-> ##[20:80] (!pins.we_n && pins.addr == held_addr && pins.dq_out == CMD_RESET))
        else $error("identifier mode not left by reset");
    c_fail: cover property (rsp_valid && rsp_fail);
    c_erase: cover property (take && cmd.op == FCSM_OP_CHIP_ERASE);
    c_ident: cover property (take && cmd.op == FCSM_OP_AUTOSEL);
endmodule : fcsm_host_checker

bind fcsm_host fcsm_host_checker u_chk (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .cmd(cmd),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_fail(rsp_fail), .pins(pins), .dq_in(dq_in));

// *** bench/test_fcsm_host.sv ***
// self-checking bench: host sequencer against the behavioural flash
`timescale 1ns/1ns

module test_fcsm_host;
    import fcsm_pkg::*;
    `define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
        $display("Error %0t: got %h expected %h", $time, got, exp); end end
    typedef struct {logic [7:0] d; logic f; bit chk;} fcsm_exp_t;
    localparam logic [7:0] IDS [3]  = '{8'h3c, 8'h5e, 8'hc3}; // arbitrary codes
    localparam logic [7:0] OFFS [3] = '{8'h00, 8'h11, 8'h01};
    localparam logic [7:0] PROT     = 8'h25;
    logic              core_clk = 1'b0;
    logic              rst = 1'b1;
    logic              clk_en = 1'b1;
    fcsm_cmd_t         cmd = '0;
    logic              cmd_valid = 1'b0;
    logic              cmd_ready, rsp_valid, rsp_fail;
    logic [7:0]        rsp_data, dq_in;
    fcsm_pins_t        pins;
    int unsigned       busy_len = 1;
    int                fail_count = 0;
    int                cmp_count = 0;
    int                cycles = 0;
    logic [7:0]        mem [16];
    fcsm_exp_t         exp_q [$];
    ////////////////////////////////////////////////////////////////
    initial forever #50 core_clk = ~core_clk;

    fcsm_host dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .rsp_fail(rsp_fail), .pins(pins), .dq_in(dq_in));
    fcsm_flash_model #(.MAKER_CODE(IDS[0]), .CONT_CODE(IDS[1]), .DEVICE_CODE(IDS[2]),
        .PROT_MAP(PROT)) u_flash (.pins(pins), .busy_len(busy_len), .dq_in(dq_in));

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task automatic issue(input fcsm_op_t op, input logic [18:0] a, input logic [7:0] d,
                         input logic [7:0] ed, input logic ef, input bit chk);
        exp_q.push_back('{ed, ef, chk});
        @(posedge core_clk iff cmd_ready === 1'b1);
        cmd       <= '{op: op, addr: a, data: d};
        cmd_valid <= 1'b1;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
    endtask : issue

    task automatic rd(input logic [18:0] a);
        issue(FCSM_OP_READ, a, 8'h00, mem[a[3:0]], 1'b0, 1'b1);
    endtask : rd

    // a program that tries to raise a bit is expected to end in the failure path
    task automatic prog(input logic [18:0] a, input logic [7:0] d);
        logic bad;
        bad = |(d & ~mem[a[3:0]]);
        mem[a[3:0]] &= d;
        issue(FCSM_OP_PROGRAM, a, d, mem[a[3:0]], bad, !bad);
    endtask : prog

    always @(posedge core_clk) begin
        fcsm_exp_t e;
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("Error %0t: unexpected response", $time);
            end else begin
                e = exp_q.pop_front();
                if (e.chk) `CHK(rsp_data, e.d)
                `CHK(rsp_fail, e.f)
            end
        end
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 30000) begin
            fail_count++;
            $display("Error %0t: run did not finish", $time);
            print_verdict();
        end
    end

    initial begin
        logic [18:0] a;
        void'($urandom(32'hf21115bf));
        foreach (mem[i]) mem[i] = 8'hff;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(19'($urandom));
        $display("test power-up reads done");
        for (int i = 0; i < 8; i++) begin
            busy_len = (i % 2) ? 6 : 1;
            a = 19'($urandom);
            prog(a, 8'($urandom));
            rd(a);
        end
        prog(a, 8'h0f);
        prog(a, 8'hf0);
        rd(a);
        fork
            rd(a);
            begin
                repeat (4) @(posedge core_clk);
                clk_en <= 1'b0;
                repeat (3) @(posedge core_clk);
                clk_en <= 1'b1;
            end
        join
        $display("test programming done");
        for (int i = 0; i < 3; i++)
            issue(FCSM_OP_AUTOSEL, {3'($urandom), 8'($urandom), OFFS[i]}, 8'h00, IDS[i], 1'b0, 1'b1);
        for (int s = 0; s < 8; s++)
            issue(FCSM_OP_AUTOSEL, {3'(s), 16'h0002}, 8'h00, {7'h00, PROT[s]}, 1'b0, 1'b1);
        rd(a);
        $display("test identifier done");
        a = 19'($urandom);
        issue(FCSM_OP_RESET, a, 8'h00, 8'h00, 1'b0, 1'b0);
        rd(a);
        busy_len = 5;
        issue(FCSM_OP_CHIP_ERASE, 19'($urandom), 8'h00, 8'hff, 1'b0, 1'b1);
        foreach (mem[i]) mem[i] = 8'hff;
        for (int i = 0; i < 4; i++) rd(19'($urandom));
        $display("test reset and erase done");
        wait (exp_q.size() == 0);
        repeat (4) @(posedge core_clk);
        print_verdict();
    end
endmodule : test_fcsm_host

// *** core/fcsm_host.sv ***
// host-side sequencer that issues command cycles and reads to a parallel flash
//
// Summary of operation
// RULE1 - device ignores strobe glitches under 5 ns; host strobes last whole cycles
// RULE2 - device sees no write while gate low or select/strobe high
// RULE3 - host writes only with select and strobe low, gate high
// RULE4 - device refuses commands on strobe rise if strobe low at power-up
// RULE5 - device powers up in read-array mode, reads need no command
// RULE6 - unexpected address or data in a sequence returns device to read-array
// RULE7 - device takes address on the later falling edge of select or strobe
// RULE8 - device takes data on the earlier rising edge of select or strobe
// RULE9 - device returns to read-array by itself after program or erase
// RULE10 - erase-suspend reads give status inside suspended sectors, array elsewhere
// RULE11 - reset command returns to read-array, address ignored
// RULE12 - reset aborts an unfinished erase sequence, ignored during erasing
// RULE13 - reset aborts an unfinished program sequence, ignored during programming
// RULE14 - reset aborts autoselect; host writes reset to leave identifier mode
// RULE15 - on failure flag host writes reset, device returns to read-array
// RULE16 - three-write entry gives identifier mode, readable repeatedly at any address
// RULE17 - low address byte 00, 11, 01 selects maker, continuation, device codes
// RULE18 - sector address with offset 02 reads 01 protected, 00 unprotected
// RULE19 - byte program is two unlocks, set-up, then address and data
// RULE20 - device ignores commands while programming, any address order allowed
// RULE21 - programming only clears bits, only erase sets them
// RULE22 - chip erase is unlock, unlock, set-up, unlock, unlock, erase command
// RULE23 - unlocks write aa to 555 then 55 to 2aa; program set-up a0
// RULE24 - chip erase writes 80 to 555 third and 10 to 555 sixth
// RULE25 - identifier entry writes 90 to 555 after the two unlocks
// RULE26 - reset command is one write of f0 at any address
`timescale 1ns/1ns

module fcsm_host
    import fcsm_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              clk_en,
    input  wire fcsm_cmd_t         cmd,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    output logic                   rsp_fail,
    output fcsm_pins_t             pins,
    input  wire logic [DATA_W-1:0] dq_in
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_W_SETUP,
        ST_W_PULSE,
        ST_W_HOLD,
        ST_R_ACCESS,
        ST_R_RECOVER,
        ST_DONE
    } fcsm_state_t;

    fcsm_state_t       state;
    logic [3:0]        cnt;
    logic [2:0]        idx;
    fcsm_cmd_t         cur;
    logic [DATA_W-1:0] prev_dq;
    logic              have_prev;
    logic              again;
    logic              fail;
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic [DATA_W-1:0] dq_s3;
    logic [DATA_W-1:0] dq_stable;
    fcsm_wr_t          wr;

    ////////////////////////////////////////////////////////////////////////////////////////
    // address and data of each write of a sequence

    function automatic fcsm_wr_t fcsm_step(input fcsm_op_t          op,
                                           input logic [2:0]        i,
                                           input logic [ADDR_W-1:0] a,
                                           input logic [DATA_W-1:0] d);
        fcsm_wr_t w;
        w.addr = UNLOCK1_ADDR;                                       // RULE23
        w.data = UNLOCK1_DATA;                                       // RULE23
        case (i)
            STEP_UNLOCK2, STEP_FIFTH: begin
                w.addr = UNLOCK2_ADDR;                               // RULE23
                w.data = UNLOCK2_DATA;                               // RULE23
            end
            STEP_SETUP: begin
                if (op == FCSM_OP_PROGRAM) begin
                    w.data = CMD_PROGRAM;                            // RULE23
                end else if (op == FCSM_OP_CHIP_ERASE) begin
                    w.data = CMD_ERASE_SETUP;                        // RULE24
                end else begin
                    w.data = CMD_AUTOSELECT;                         // RULE25
                end
            end
            STEP_FOURTH: begin
                if (op == FCSM_OP_PROGRAM) begin
                    w.addr = a;                                      // RULE19
                    w.data = d;                                      // RULE19
                end
            end
            STEP_SIXTH: begin
                w.data = CMD_CHIP_ERASE;                             // RULE24
            end
            default: begin
            end
        endcase
        // reset takes the caller's address unchanged: the device ignores it
        if (op == FCSM_OP_RESET) begin
            w.addr = a;                                              // RULE11
            w.data = CMD_RESET;                                      // RULE26
        end
        return w;
    endfunction : fcsm_step

    function automatic logic [2:0] fcsm_writes(input fcsm_op_t op);
        case (op)
            FCSM_OP_PROGRAM:    return PROGRAM_WRITES;               // RULE19
            FCSM_OP_CHIP_ERASE: return CHIP_ERASE_WRITES;            // RULE22
            FCSM_OP_AUTOSEL:    return AUTOSEL_WRITES;               // RULE16
            FCSM_OP_RESET:      return RESET_WRITES;
            default:            return 3'h0;
        endcase
    endfunction : fcsm_writes

    assign wr = fcsm_step(cur.op, idx, cur.addr, cur.data);

    ////////////////////////////////////////////////////////////////////////////////////////
    // data pins: three stages, a value counts once stages two and three agree

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dq_s1     <= '0;
            dq_s2     <= '0;
            dq_s3     <= '0;
            dq_stable <= '0;
        end else if (clk_en) begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
            dq_s3 <= dq_s2;
            if (dq_s2 == dq_s3) begin
                dq_stable <= dq_s3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // sequencer and pin drive
    // strobes rest high from reset, so no write is pending as the device powers up

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state     <= ST_IDLE;
            cnt       <= '0;
            idx       <= '0;
            cur       <= '{op: FCSM_OP_READ, addr: '0, data: '0};
            prev_dq   <= '0;
            have_prev <= 1'b0;
            again     <= 1'b0;
            fail      <= 1'b0;
            result    <= '0;
            pins      <= PINS_IDLE;                                  // RULE4
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data  <= '0;
            rsp_fail  <= 1'b0;
        end else if (clk_en) begin
            rsp_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        cur       <= cmd;
                        idx       <= '0;
                        cnt       <= '0;
                        fail      <= 1'b0;
                        have_prev <= 1'b0;
                        result    <= '0;
                        // plain reads need no command first
                        state     <= (cmd.op == FCSM_OP_READ) ? ST_R_ACCESS
                                                              : ST_W_SETUP; // RULE5
                    end
                end
                ST_W_SETUP: begin
                    // select falls first, strobe later: address stable at strobe fall
                    pins.addr    <= wr.addr;                         // RULE7
                    pins.dq_out  <= wr.data;
                    pins.dq_oe_n <= 1'b0;
                    pins.ce_n    <= 1'b0;
                    pins.oe_n    <= 1'b1;                            // RULE3
                    cnt          <= cnt + 4'h1;
                    if (cnt == CNT_WR_SETUP) begin
                        cnt   <= '0;
                        state <= ST_W_PULSE;
                    end
                end
                ST_W_PULSE: begin
                    // a pulse of whole cycles, far above the glitch filter
                    pins.we_n <= 1'b0;                               // RULE1
                    cnt       <= cnt + 4'h1;
                    if (cnt == CNT_WR_PULSE) begin
                        cnt       <= '0;
                        state     <= ST_W_HOLD;
                    end
                end
                ST_W_HOLD: begin
                    pins.we_n <= 1'b1;                               // RULE8
                    cnt       <= cnt + 4'h1;
                    if (cnt == CNT_WR_HOLD) begin
                        // data stays driven until after the strobe has risen
                        cnt          <= '0;
                        pins.ce_n    <= 1'b1;                        // RULE2
                        pins.dq_oe_n <= 1'b1;
                        if (idx + 3'h1 < fcsm_writes(cur.op)) begin
                            idx   <= idx + 3'h1;
                            state <= ST_W_SETUP;                     // RULE22
                        end else if (cur.op == FCSM_OP_RESET) begin
                            state <= ST_DONE;                        // RULE11
                        end else begin
                            // program and erase run unattended; host only polls
                            state <= ST_R_ACCESS;                    // RULE19
                        end
                    end
                end
                ST_R_ACCESS: begin
                    pins.addr    <= cur.addr;                        // RULE17
                    pins.dq_oe_n <= 1'b1;
                    pins.ce_n    <= 1'b0;
                    pins.oe_n    <= 1'b0;
                    pins.we_n    <= 1'b1;                            // RULE2
                    cnt          <= cnt + 4'h1;
                    if (cnt == CNT_RD_ACCESS) begin
                        cnt       <= '0;
                        pins.ce_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        state     <= ST_R_RECOVER;
                        again     <= 1'b0;
                        case (cur.op)
                            FCSM_OP_AUTOSEL: begin
                                result <= dq_stable;                 // RULE18
                                cur.op <= FCSM_OP_RESET;             // RULE14
                                idx    <= '0;
                            end
                            FCSM_OP_PROGRAM, FCSM_OP_CHIP_ERASE: begin
                                prev_dq   <= dq_stable;
                                have_prev <= 1'b1;
                                result    <= dq_stable;
                                if (!have_prev) begin
                                    again <= 1'b1;
                                end else if (dq_stable[TOGGLE_BIT] == prev_dq[TOGGLE_BIT]) begin
                                    // toggling stopped: device is back in read-array
                                    again <= 1'b0;                   // RULE9
                                end else if (dq_stable[FAIL_BIT] && prev_dq[FAIL_BIT]) begin
                                    fail   <= 1'b1;                  // RULE15
                                    cur.op <= FCSM_OP_RESET;         // RULE15
                                    idx    <= '0;
                                end else begin
                                    // resets would be ignored while the algorithm runs
                                    again <= 1'b1;                   // RULE20
                                end
                            end
                            default: begin
                                result <= dq_stable;
                            end
                        endcase
                    end
                end
                ST_R_RECOVER: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == CNT_RD_RECOVER) begin
                        cnt <= '0;
                        if (again) begin
                            state <= ST_R_ACCESS;
                        end else if (cur.op == FCSM_OP_RESET) begin
                            state <= ST_W_SETUP;                     // RULE14
                        end else begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    rsp_valid <= 1'b1;
                    rsp_data  <= result;
                    rsp_fail  <= fail;
                    state     <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                    pins  <= PINS_IDLE;
                end
            endcase
        end
    end

endmodule : fcsm_host

// *** inc/fcsm_pkg.sv ***
// constants, types and pin bundle for the flash command sequencer (host side)
package fcsm_pkg;

    localparam int unsigned CLK_PERIOD_NS     = 100;
    // bus timing figures, in nanoseconds
    localparam int unsigned T_WR_SETUP_NS     = 100;
    localparam int unsigned T_WR_PULSE_NS     = 100;
    localparam int unsigned T_WR_HOLD_NS      = 100;
    localparam int unsigned T_RD_ACCESS_NS    = 150;
    localparam int unsigned T_RD_RECOVER_NS   = 100;
    // least times, rounded up to whole cycles
    localparam int unsigned WR_SETUP_CYC   = (T_WR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WR_PULSE_CYC   = (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WR_HOLD_CYC    = (T_WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RD_ACCESS_CYC  = (T_RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RD_RECOVER_CYC = (T_RD_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // cycles from a pin change to the filtered data value
    localparam int unsigned SYNC_LAT       = 4;

    localparam logic [3:0] CNT_WR_SETUP   = 4'(WR_SETUP_CYC);
    localparam logic [3:0] CNT_WR_PULSE   = 4'(WR_PULSE_CYC - 1);
    localparam logic [3:0] CNT_WR_HOLD    = 4'(WR_HOLD_CYC);
    localparam logic [3:0] CNT_RD_ACCESS  = 4'(RD_ACCESS_CYC + SYNC_LAT);
    localparam logic [3:0] CNT_RD_RECOVER = 4'(RD_RECOVER_CYC - 1);

    localparam int unsigned ADDR_W = 19;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] UNLOCK1_ADDR    = 19'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK2_ADDR    = 19'h002aa;
    localparam logic [DATA_W-1:0] UNLOCK1_DATA    = 8'haa;
    localparam logic [DATA_W-1:0] UNLOCK2_DATA    = 8'h55;
    localparam logic [DATA_W-1:0] CMD_PROGRAM     = 8'ha0;
    localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [DATA_W-1:0] CMD_CHIP_ERASE  = 8'h10;
    localparam logic [DATA_W-1:0] CMD_AUTOSELECT  = 8'h90;
    localparam logic [DATA_W-1:0] CMD_RESET       = 8'hf0;

    localparam int unsigned TOGGLE_BIT = 6;
    localparam int unsigned FAIL_BIT   = 5;

    localparam logic [2:0] PROGRAM_WRITES    = 3'h4;
    localparam logic [2:0] CHIP_ERASE_WRITES = 3'h6;
    localparam logic [2:0] AUTOSEL_WRITES    = 3'h3;
    localparam logic [2:0] RESET_WRITES      = 3'h1;
    localparam logic [2:0] STEP_UNLOCK2      = 3'h1;
    localparam logic [2:0] STEP_SETUP        = 3'h2;
    localparam logic [2:0] STEP_FOURTH       = 3'h3;
    localparam logic [2:0] STEP_FIFTH        = 3'h4;
    localparam logic [2:0] STEP_SIXTH        = 3'h5;

    typedef enum logic [2:0] {
        FCSM_OP_READ,
        FCSM_OP_PROGRAM,
        FCSM_OP_CHIP_ERASE,
        FCSM_OP_AUTOSEL,
        FCSM_OP_RESET
    } fcsm_op_t;

    typedef struct packed {
        fcsm_op_t          op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fcsm_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fcsm_wr_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe_n;
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
    } fcsm_pins_t;

    localparam fcsm_pins_t PINS_IDLE = '{addr: '0, dq_out: '0, dq_oe_n: 1'b1,
                                         ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};

endpackage : fcsm_pkg
